// File: design/urm_regs.svh
`ifndef URM_REGS_SVH
`define URM_REGS_SVH
// Register addresses, three-bit
`define URM_A_DATA    3'h0
`define URM_A_MASK    3'h1
`define URM_A_IDENT   3'h2
`define URM_A_FORMAT  3'h3
`define URM_A_MODEM   3'h4
`define URM_A_LINE    3'h5
`define URM_A_MSTAT   3'h6
`define URM_A_SCRATCH 3'h7
// Field positions
`define URM_DLAB      7
`define URM_FEN       0
`define URM_RXRST     1
`define URM_TXRST     2
`define URM_DMA       3
`define URM_TRIG_HI   7
`define URM_TRIG_LO   6
`define URM_MASK_RX   0
`define URM_MASK_TX   1
`define URM_MASK_LS   2
`define URM_MASK_MS   3
// Interrupt identification codes
`define URM_ID_LINE   4'h6
`define URM_ID_TMO    4'hC
`define URM_ID_RXD    4'h4
`define URM_ID_TXE    4'h2
`define URM_ID_MSR    4'h0
`define URM_ID_NONE   4'h1
// Trigger levels
`define URM_TRIG_1    5'h01
`define URM_TRIG_4    5'h04
`define URM_TRIG_8    5'h08
`define URM_TRIG_14   5'h0E
// Reset values
`define URM_RST_BYTE  8'h00
`endif

// File: design/urm_pkg.sv
package urm_pkg;
   // Receive entry: data plus error tags
   typedef struct packed {
      logic       brk;
      logic       frm;
      logic       par;
      logic [7:0] data;
   } urm_rx_t;
   // Host bus request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } urm_bus_t;
endpackage

// File: design/urm_rx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module urm_rx_mem import urm_pkg::*; #(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic          clk,    // Clock
   input  wire logic          we,     // Write strobe
   input  wire logic [AW-1:0] waddr,  // Write index
   input  wire urm_rx_t       wdata,  // Write entry
   input  wire logic [AW-1:0] raddr,  // Read index
   output urm_rx_t            rdata   // Registered read entry
);
   initial begin
      if (DEPTH != (1 << AW)) $error("urm_rx_mem: DEPTH must be 2**AW");
   end
   urm_rx_t mem [DEPTH];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // urm_rx_mem
`default_nettype wire

// File: design/urm_regmap.sv
`timescale 1ns/1ps
`default_nettype none
`include "urm_regs.svh"
// How it works
// - Four mask bits gate five sources (bit 0 covers receive and timeout); unmasked pending ones show in identification.
// - FIFO mode: receive interrupt holds while fill is at or above trigger.
// - Data ready sets on a character entering the queue, clears when empty.
// - FIFO on with all masks clear gives polled operation via line status.
// - Overrun bit sets on a receive overrun.
// - Break, framing, parity bits follow the character at the queue head.
// - Bit 5 holding empty; bit 6 only when queue and shifter empty.
// - Global error bit set in FIFO mode only, while any queued character has an error.
// - Mask bit 0 enables receive interrupt: holding full or trigger reached.
// - Mask bit 1 raises transmit interrupt on empty, at once if already.
// - Mask bit 2 interrupts on line status bits 1 to 4.
// - Mask bit 3 gates the modem status interrupt.
// - Upper four mask bits read zero.
// - Identification nibble encodes highest pending source; 0001 means none.
// - Line status read clears line interrupt; modem interrupt follows modemDelta, not cleared by a read.
// - Transmit interrupt clears on identification read showing it, or holding write.
// - Trigger select 00/01/10/11 gives 1/4/8/14 characters.
module urm_regmap import urm_pkg::*; #(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic       clk,          // Clock, 200 MHz
   input  wire logic       srst,         // Sync reset, active high
   input  wire urm_bus_t   bus,          // Host request, one-cycle strobes
   output logic [7:0]      rdata,        // Read data, registered
   input  wire logic       rxPush,       // Shifter delivers character
   input  wire urm_rx_t    rxChar,       // Character with tags
   input  wire logic       txPop,        // Shifter took a transmit byte
   input  wire logic       txShiftIdle,  // Transmit shifter empty
   input  wire logic       rxTimeout,    // Receive timeout level
   input  wire logic       modemDelta,   // Any modem delta bit set
   input  wire logic [7:0] modemState,   // Modem input state byte
   output logic [7:0]      txData,       // Byte for the shifter
   output logic            txValid,      // Transmit byte present
   output logic [15:0]     divisor,      // Baud divisor
   output logic [7:0]      lineFormat,   // Line format register
   output logic [7:0]      modemCtrl,    // Modem output control
   output logic            irq           // Interrupt, active high
);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   initial begin
      if (DEPTH != (1 << AW) || DEPTH < 16) $error("urm_regmap: bad DEPTH");
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic dlab;
   logic rdData, wrData, wrMask, rdIdent, wrQueue, rdLine, rdModem;
   always_comb begin
      dlab    = lineFormat[`URM_DLAB];
      rdData  = bus.rd && bus.addr == `URM_A_DATA  && !dlab;
      wrData  = bus.wr && bus.addr == `URM_A_DATA  && !dlab;
      wrMask  = bus.wr && bus.addr == `URM_A_MASK  && !dlab;
      rdIdent = bus.rd && bus.addr == `URM_A_IDENT;
      wrQueue = bus.wr && bus.addr == `URM_A_IDENT;
      rdLine  = bus.rd && bus.addr == `URM_A_LINE;
      rdModem = bus.rd && bus.addr == `URM_A_MSTAT;
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [3:0] mask_q, mask_d;
   logic [7:0] dll_q, dll_d, dlm_q, dlm_d, lcr_q, lcr_d, mcr_q, mcr_d, spr_q, spr_d;
   logic       fen_q, fen_d;
   logic [1:0] trig_q, trig_d;
   logic       dma_q, dma_d;
   always_comb begin
      mask_d = mask_q;
      dll_d  = dll_q;
      dlm_d  = dlm_q;
      lcr_d  = lcr_q;
      mcr_d  = mcr_q;
      spr_d  = spr_q;
      fen_d  = fen_q;
      trig_d = trig_q;
      dma_d  = dma_q;
      if (wrMask) mask_d = bus.wdata[3:0];
      if (bus.wr && dlab && bus.addr == `URM_A_DATA) dll_d = bus.wdata;
      if (bus.wr && dlab && bus.addr == `URM_A_MASK) dlm_d = bus.wdata;
      if (bus.wr && bus.addr == `URM_A_FORMAT) lcr_d = bus.wdata;
      if (bus.wr && bus.addr == `URM_A_MODEM) mcr_d = {3'h0, bus.wdata[4:0]};
      if (bus.wr && bus.addr == `URM_A_SCRATCH) spr_d = bus.wdata;
      if (wrQueue) begin
         fen_d = bus.wdata[`URM_FEN];
         if (bus.wdata[`URM_FEN]) begin
            trig_d = bus.wdata[`URM_TRIG_HI:`URM_TRIG_LO];
            dma_d  = bus.wdata[`URM_DMA];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         mask_q <= 4'h0;
         dll_q  <= `URM_RST_BYTE;
         dlm_q  <= `URM_RST_BYTE;
         lcr_q  <= `URM_RST_BYTE;
         mcr_q  <= `URM_RST_BYTE;
         spr_q  <= `URM_RST_BYTE;
         fen_q  <= 1'b0;
         trig_q <= 2'h0;
         dma_q  <= 1'b0;
      end else begin
         mask_q <= mask_d;
         dll_q  <= dll_d;
         dlm_q  <= dlm_d;
         lcr_q  <= lcr_d;
         mcr_q  <= mcr_d;
         spr_q  <= spr_d;
         fen_q  <= fen_d;
         trig_q <= trig_d;
         dma_q  <= dma_d;
      end
   end
   assign divisor    = {dlm_q, dll_q};
   assign lineFormat = lcr_q;
   assign modemCtrl  = mcr_q;

   // ----------------------------------------
   // Receive queue
   // ----------------------------------------
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic [DEPTH-1:0] err_q, err_d;
   logic          ovr_q, ovr_d;
   logic          pop, push, rxRst, txRst, entErr;
   logic [AW:0]   cap;
   urm_rx_t       head;
   always_comb begin
      rxRst  = wrQueue && bus.wdata[`URM_FEN] && bus.wdata[`URM_RXRST];
      cap    = fen_q ? FULL : (AW+1)'(1);
      pop    = rdData && cnt_q != '0;
      push   = rxPush && (cnt_q - (AW+1)'(pop)) < cap;
      entErr = rxChar.brk || rxChar.frm || rxChar.par;
      wp_d   = wp_q;
      rp_d   = rp_q;
      cnt_d  = cnt_q;
      err_d  = err_q;
      ovr_d  = ovr_q;
      if (pop) begin
         rp_d = rp_q + AW'(1);
         err_d[rp_q] = 1'b0;
      end
      if (push) begin
         wp_d = wp_q + AW'(1);
         err_d[wp_q] = entErr;
      end
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (rdLine) ovr_d = 1'b0;
      if (rxPush && !push) ovr_d = 1'b1;
      if (rxRst) begin
         wp_d  = '0;
         rp_d  = '0;
         cnt_d = '0;
         err_d = '0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         err_q <= '0;
         ovr_q <= 1'b0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         err_q <= err_d;
         ovr_q <= ovr_d;
      end
   end
   urm_rx_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk   (clk),
      .we    (push),
      .waddr (wp_q),
      .wdata (rxChar),
      .raddr (rp_d),
      .rdata (head)
   );

   // ----------------------------------------
   // Transmit queue (count only; data to shifter)
   // ----------------------------------------
   logic [AW:0] txCnt_q, txCnt_d;
   logic [7:0]  txb_q, txb_d;
   logic        txe_q, txe_d;
   always_comb begin
      txRst   = wrQueue && bus.wdata[`URM_FEN] && bus.wdata[`URM_TXRST];
      txCnt_d = txCnt_q + (AW+1)'(wrData && txCnt_q < (fen_q ? FULL : (AW+1)'(1)))
                - (AW+1)'(txPop && txCnt_q != '0);
      txb_d   = wrData ? bus.wdata : txb_q;
      if (txRst) txCnt_d = '0;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         txCnt_q <= '0;
         txb_q   <= `URM_RST_BYTE;
      end else begin
         txCnt_q <= txCnt_d;
         txb_q   <= txb_d;
      end
   end
   assign txData  = txb_q;
   assign txValid = txCnt_q != '0;

   // ----------------------------------------
   // Status and interrupt sources
   // ----------------------------------------
   logic [4:0] trigLvl;
   logic [7:0] lineSt;
   logic       srcLine, srcRx, srcTmo, srcTx, srcMs, lsi_q, lsi_d, thrEmpty;
   logic       txi_q, txi_d, txArm_q, txArm_d;
   logic [3:0] ident;
   always_comb begin
      unique case (trig_q)
         2'b00: trigLvl = `URM_TRIG_1;
         2'b01: trigLvl = `URM_TRIG_4;
         2'b10: trigLvl = `URM_TRIG_8;
         2'b11: trigLvl = `URM_TRIG_14;
      endcase
      thrEmpty = txCnt_q == '0;
      lineSt[0] = cnt_q != '0;
      lineSt[1] = ovr_q;
      lineSt[2] = lineSt[0] && head.par;
      lineSt[3] = lineSt[0] && head.frm;
      lineSt[4] = lineSt[0] && head.brk;
      lineSt[5] = thrEmpty;
      lineSt[6] = thrEmpty && txShiftIdle;
      lineSt[7] = fen_q && |err_q;
      // Line status interrupt: set wins over read clear
      lsi_d = rdLine ? 1'b0 : lsi_q;
      if ((ovr_d && !ovr_q) || (push && entErr && cnt_q == '0)) lsi_d = 1'b1;
      if (pop && cnt_q > (AW+1)'(1)) lsi_d = lsi_d || err_q[rp_q + AW'(1)];
      srcLine = mask_q[`URM_MASK_LS] && lsi_q;
      srcRx   = mask_q[`URM_MASK_RX] && (fen_q ? {1'b0, cnt_q} >= {1'b0, trigLvl}
                                                : cnt_q != '0);
      srcTmo  = mask_q[`URM_MASK_RX] && fen_q && rxTimeout && cnt_q != '0;
      srcTx   = mask_q[`URM_MASK_TX] && txi_q;
      srcMs   = mask_q[`URM_MASK_MS] && modemDelta;
      if (srcLine)     ident = `URM_ID_LINE;
      else if (srcTmo) ident = `URM_ID_TMO;
      else if (srcRx)  ident = `URM_ID_RXD;
      else if (srcTx)  ident = `URM_ID_TXE;
      else if (srcMs)  ident = `URM_ID_MSR;
      else             ident = `URM_ID_NONE;
   end
   // Transmit interrupt flag
   always_comb begin
      txArm_d = mask_q[`URM_MASK_TX];
      txi_d   = txi_q;
      if ((rdIdent && ident == `URM_ID_TXE) || wrData) txi_d = 1'b0;
      if (thrEmpty && txe_q == 1'b0) txi_d = 1'b1;
      if (mask_q[`URM_MASK_TX] && !txArm_q && thrEmpty) txi_d = 1'b1;
      txe_d = thrEmpty;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         txi_q   <= 1'b0;
         txArm_q <= 1'b0;
         txe_q   <= 1'b1;
         lsi_q   <= 1'b0;
      end else begin
         txi_q   <= txi_d;
         txArm_q <= txArm_d;
         txe_q   <= txe_d;
         lsi_q   <= lsi_d;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   logic [7:0] rd_d;
   always_comb begin
      rd_d = rdata;
      if (bus.rd) begin
         unique case (bus.addr)
            `URM_A_DATA:    rd_d = dlab ? dll_q : head.data;
            `URM_A_MASK:    rd_d = dlab ? dlm_q : {4'h0, mask_q};
            `URM_A_IDENT:   rd_d = {fen_q, fen_q, 2'h0, ident};
            `URM_A_FORMAT:  rd_d = lcr_q;
            `URM_A_MODEM:   rd_d = mcr_q;
            `URM_A_LINE:    rd_d = lineSt;
            `URM_A_MSTAT:   rd_d = modemState;
            `URM_A_SCRATCH: rd_d = spr_q;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (srst) rdata <= `URM_RST_BYTE;
      else      rdata <= rd_d;
   end
   assign irq = ident != `URM_ID_NONE && mcr_q[3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_maskWrite;
      wrMask && bus.wdata[`URM_MASK_TX] && !mask_q[`URM_MASK_TX] && thrEmpty;
   endsequence
   a_mask_reset: assert property (@(posedge clk) srst |=> mask_q == 4'h0)
      else $error("mask not cleared by reset");
   a_tx_enable_now: assert property (@(posedge clk) disable iff (srst)
      s_maskWrite ##1 !wrData |=> txi_q)
      else $error("transmit interrupt missing after enable");
   a_tx_clear_write: assert property (@(posedge clk) disable iff (srst)
      wrData && !(thrEmpty && !txe_q) |=> !txi_q)
      else $error("transmit interrupt not cleared by write");
   a_ident_none: assert property (@(posedge clk) disable iff (srst)
      mask_q == 4'h0 |-> ident == `URM_ID_NONE)
      else $error("ident shows source with all masks clear");
   a_ready_flag: assert property (@(posedge clk) disable iff (srst)
      push |=> lineSt[0])
      else $error("data ready not set after push");
   a_overrun_set: assert property (@(posedge clk) disable iff (srst)
      rxPush && !push |=> lineSt[1])
      else $error("overrun not flagged");
   a_line_first: assert property (@(posedge clk) disable iff (srst)
      srcLine |-> ident == `URM_ID_LINE)
      else $error("line status not highest priority");
   a_rx_trigger: assert property (@(posedge clk) disable iff (srst)
      fen_q && mask_q[0] && !srcLine && !srcTmo && cnt_q >= (AW+1)'(trigLvl)
      |-> ident == `URM_ID_RXD)
      else $error("receive trigger not reported");
   a_mask_upper: assert property (@(posedge clk) disable iff (srst)
      bus.rd && bus.addr == `URM_A_MASK && !dlab |=> rdata[7:4] == 4'h0)
      else $error("upper mask bits not zero");
   a_shift_empty: assert property (@(posedge clk) disable iff (srst)
      lineSt[6] |-> lineSt[5])
      else $error("both-empty set while holding full");
endmodule // urm_regmap
`default_nettype wire

// File: testbench/urm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module urm_host_model import urm_pkg::*; (
   input  wire logic [7:0] rdata,  // Read data from block
   input  wire logic       clk,    // Clock
   output var urm_bus_t    bus     // Request to block
);
   initial bus = '0;
   // ----------------------------------------
   // Bus cycles, driven off the falling edge
   // ----------------------------------------
   task automatic busWrite(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      bus.wr    = 1'b0;
      bus.wdata = ~d;
   endtask
   task automatic busRead(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk);
      bus.rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
endmodule // urm_host_model
`default_nettype wire

// File: testbench/urm_regmap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "urm_regs.svh"
module urm_regmap_tb_top import urm_pkg::*; ;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   urm_bus_t    bus;
   logic [7:0]  rdata;
   logic        rxPush = 1'b0;
   urm_rx_t     rxChar = '0;
   logic        txPop = 1'b0;
   logic        txShiftIdle = 1'b1;
   logic        rxTimeout = 1'b0;
   logic        modemDelta = 1'b0;
   logic [7:0]  modemState = 8'hA5;
   logic [7:0]  txData;
   logic        txValid;
   logic [15:0] divisor;
   logic [7:0]  lineFormat;
   logic [7:0]  modemCtrl;
   logic        irq;
   int          n_errors = 0;
   int          checks_done = 0;
   logic [7:0]  v;

   always #2.5 clk = ~clk;

   urm_regmap uut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .rxPush(rxPush),
      .rxChar(rxChar), .txPop(txPop), .txShiftIdle(txShiftIdle), .rxTimeout(rxTimeout),
      .modemDelta(modemDelta), .modemState(modemState), .txData(txData),
      .txValid(txValid), .divisor(divisor), .lineFormat(lineFormat),
      .modemCtrl(modemCtrl), .irq(irq));
   urm_host_model host (.rdata(rdata), .clk(clk), .bus(bus));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      host.busRead(a, d);
      chk(what, {8'h00, exp}, {8'h00, d});
   endtask
   task automatic push(input logic [7:0] d);
      @(negedge clk);
      rxPush = 1'b1;
      rxChar = '{brk: 1'b0, frm: 1'b0, par: 1'b0, data: d};
      @(negedge clk);
      rxPush = 1'b0;
      rxChar = '{brk: 1'b1, frm: 1'b1, par: 1'b1, data: ~d};
   endtask
   task automatic pushErr(input logic [7:0] d, input logic [2:0] t);
      @(negedge clk);
      rxPush = 1'b1;
      rxChar = '{brk: t[2], frm: t[1], par: t[0], data: d};
      @(negedge clk);
      rxPush = 1'b0;
   endtask
   task automatic pop();
      @(negedge clk);
      txPop = 1'b1;
      @(negedge clk);
      txPop = 1'b0;
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic scnReset();
      rdChk(`URM_A_MASK, 8'h00, "maskAtReset");
      rdChk(`URM_A_IDENT, 8'h01, "identAtReset");
      chk("irqAtReset", 16'h0000, {15'h0, irq});
      host.busWrite(`URM_A_MASK, 8'hF0);
      rdChk(`URM_A_MASK, 8'h00, "maskUpper");
      host.busWrite(`URM_A_SCRATCH, 8'h5A);
      rdChk(`URM_A_SCRATCH, 8'h5A, "scratch");
   endtask
   task automatic scnDivisor();
      host.busWrite(`URM_A_FORMAT, 8'h80);
      host.busWrite(`URM_A_DATA, 8'h34);
      host.busWrite(`URM_A_MASK, 8'h12);
      chk("divisor", 16'h1234, divisor);
      rdChk(`URM_A_MASK, 8'h12, "divHighRead");
      host.busWrite(`URM_A_FORMAT, 8'h03);
      rdChk(`URM_A_MASK, 8'h00, "maskAfterDiv");
      chk("lineFormat", 16'h0003, {8'h00, lineFormat});
   endtask
   task automatic scnTransmit();
      host.busWrite(`URM_A_MODEM, 8'h08);
      host.busWrite(`URM_A_MASK, 8'h02);
      @(negedge clk);
      chk("irqTxAtOnce", 16'h0001, {15'h0, irq});
      rdChk(`URM_A_IDENT, 8'h02, "identTx");
      rdChk(`URM_A_IDENT, 8'h01, "identTxRead");
      host.busWrite(`URM_A_DATA, 8'h55);
      chk("txValid", 16'h0001, {15'h0, txValid});
      rdChk(`URM_A_LINE, 8'h00, "lineTxBusy");
      pop();
      rdChk(`URM_A_IDENT, 8'h02, "identTxEmpty");
      host.busWrite(`URM_A_DATA, 8'h66);
      chk("txData", 16'h0066, {8'h00, txData});
      rdChk(`URM_A_IDENT, 8'h01, "identTxWrite");
      txShiftIdle = 1'b0;
      pop();
      rdChk(`URM_A_LINE, 8'h20, "lineShiftBusy");
      host.busWrite(`URM_A_DATA, 8'h77);
      rdChk(`URM_A_IDENT, 8'h01, "identTxWrClr");
      pop();
      txShiftIdle = 1'b1;
   endtask
   task automatic scnOverrun();
      host.busWrite(`URM_A_MASK, 8'h04);
      push(8'h11);
      push(8'h22);
      chk("irqLine", 16'h0001, {15'h0, irq});
      rdChk(`URM_A_LINE, 8'h63, "lineOverrun");
      rdChk(`URM_A_IDENT, 8'h01, "identLineRead");
      rdChk(`URM_A_DATA, 8'h11, "holdFirst");
      host.busRead(`URM_A_LINE, v);
      chk("rxReadyEmpty", 16'h0000, {15'h0, v[0]});
   endtask
   task automatic scnTrigger();
      int lvl[4] = '{1, 4, 8, 14};
      host.busWrite(`URM_A_MASK, 8'h01);
      for (int k = 0; k < 4; k++) begin
         host.busWrite(`URM_A_IDENT, {k[1:0], 6'h03});
         for (int i = 1; i < lvl[k]; i++) push(i[7:0]);
         rdChk(`URM_A_IDENT, 8'hC1, "identBelowTrig");
         push(8'hEE);
         rdChk(`URM_A_IDENT, 8'hC4, "identAtTrig");
         rdChk(`URM_A_DATA, (lvl[k] == 1) ? 8'hEE : 8'h01, "fifoHead");
         rdChk(`URM_A_IDENT, 8'hC1, "identDropTrig");
      end
   endtask
   task automatic scnModem();
      modemDelta = 1'b1;
      host.busWrite(`URM_A_MASK, 8'h0A);
      rdChk(`URM_A_IDENT, 8'hC2, "identTxOverMsr");
      rdChk(`URM_A_IDENT, 8'hC0, "identModem");
      modemDelta = 1'b0;
      rdChk(`URM_A_MSTAT, 8'hA5, "modemState");
      rdChk(`URM_A_IDENT, 8'hC1, "identModemRead");
      host.busWrite(`URM_A_MASK, 8'h00);
      push(8'h77);
      host.busRead(`URM_A_LINE, v);
      chk("polledReady", 16'h0001, {15'h0, v[0]});
      chk("polledIrq", 16'h0000, {15'h0, irq});
   endtask
   task automatic scnError();
      host.busWrite(`URM_A_IDENT, 8'h03);
      host.busWrite(`URM_A_MASK, 8'h04);
      push(8'h31);
      pushErr(8'h32, 3'b010);
      rdChk(`URM_A_LINE, 8'hE1, "lineQueuedErr");
      chk("irqCleanHead", 16'h0000, {15'h0, irq});
      rdChk(`URM_A_DATA, 8'h31, "holdClean");
      chk("irqErrHead", 16'h0001, {15'h0, irq});
      rdChk(`URM_A_IDENT, 8'hC6, "identLine");
      rdChk(`URM_A_LINE, 8'hE9, "lineHeadFrame");
      rdChk(`URM_A_IDENT, 8'hC1, "identLineClr");
      rdChk(`URM_A_DATA, 8'h32, "holdErrored");
      rdChk(`URM_A_LINE, 8'h60, "lineErrGone");
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      srst = 1'b0;
      scnReset();
      scnDivisor();
      scnTransmit();
      scnOverrun();
      scnTrigger();
      scnModem();
      scnError();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule // urm_regmap_tb_top
`default_nettype wire
